// File: verilog/spp_pkg.sv
// Package: constants, field layout and carrier types of the serial port
package spp_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] SPP_CTRL_ADDR = 8'hB0;
	localparam logic [7:0] SPP_CFG_ADDR  = 8'hB1;
	localparam logic [7:0] SPP_RATE_ADDR = 8'hB2;
	localparam logic [7:0] SPP_DATA_ADDR = 8'hB3;

	localparam int unsigned SPP_DONE_BIT = 7;
	localparam int unsigned SPP_WRITE_COLLISION_FLAG_BIT = 6;
	localparam int unsigned SPP_MODE_FAULT_FLAG_BIT = 5;
	localparam int unsigned SPP_OVR_BIT  = 4;
	localparam int unsigned SPP_MODE_HI  = 3;
	localparam int unsigned SPP_MODE_LO  = 2;
	localparam int unsigned SPP_TXE_BIT  = 1;
	localparam int unsigned SPP_EN_BIT   = 0;
	localparam int unsigned SPP_MASTER_ENABLE_BIT = 6;
	localparam int unsigned SPP_CLOCK_PHASE_BIT = 5;

	localparam logic [7:0] SPP_CTRL_RESET = 8'h06;
	localparam logic [7:0] SPP_CFG_RESET  = 8'h00;
	localparam logic [7:0] SPP_RATE_RESET = 8'h00;
	localparam logic [7:0] SPP_IDLE_BYTE  = 8'h00;

	localparam logic [1:0] SPP_MODE_3WIRE = 2'h0;
	localparam logic [1:0] SPP_MODE_4WIRE = 2'h1;

	localparam logic [2:0] SPP_LAST_BIT  = 3'h7;
	localparam logic [3:0] SPP_BITS_BYTE = 4'h8;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned SPP_SYS_PERIOD_NS = 20;
	localparam int unsigned SPP_MIN_PHASE_NS  = 20;
	localparam int unsigned SPP_MIN_PHASE_CYC =
		(SPP_MIN_PHASE_NS + SPP_SYS_PERIOD_NS - 1) / SPP_SYS_PERIOD_NS;
	localparam int unsigned SPP_MISO_MAX_NS   = 80;
	localparam int unsigned SPP_MISO_MAX_CYC  = SPP_MISO_MAX_NS / SPP_SYS_PERIOD_NS;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic {SPP_M_IDLE, SPP_M_SHIFT} spp_mstate_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       bit_wr;
		logic [2:0] bit_idx;
		logic [7:0] addr;
		logic [7:0] wdata;
	} spp_sfr_req_s;

	typedef struct packed {
		logic o;
		logic oe;
	} spp_pin_out_s;

endpackage

// File: verilog/spp_port.sv
// Serial peripheral port: control register, master shifter, slave link logic
// ****************************************************************
// Notes on behaviour
// - DMA moves bytes in master and slave
// - No DMA-only bits; same registers either way
// - Master captures one byte per byte sent
// - Every received byte is offered for storage
// - Separate requests for fill and drain channels
// - Transfer done flag sticky until cleared
// - Data write while buffer full is dropped, flagged
// - Mode fault on select low in master, 4-wire mode only
// - Slave overrun when unread byte is pending
// - Select mode sets pin direction and level
// - Buffer empty clears on write, sets on load
// - Bit zero enables the port
// - Control at B0, bit access, reset 06
// - Master clock phases at least one cycle
// - Slave data out driven within four cycles
// - Slave output changes only on link edges
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none

module spp_port
	import spp_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	input  wire spp_sfr_req_s sfr_req,
	output logic [7:0]        sfr_rdata,
	output logic              dma_tx_req,
	output logic              dma_rx_req,
	input  wire logic         link_sck,
	output spp_pin_out_s      sck_pin,
	output spp_pin_out_s      mosi_pin,
	input  wire logic         mosi_in,
	output spp_pin_out_s      miso_pin,
	input  wire logic         miso_in,
	output spp_pin_out_s      nss_pin,
	input  wire logic         nss_in
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  cfg;
		logic [7:0]  rate;
		logic [7:0]  tx_buf;
		logic [7:0]  rx_buf;
		logic        rx_full;
		logic [7:0]  shift;
		logic        cap;
		logic [3:0]  bit_cnt;
		logic [7:0]  div_cnt;
		logic        sck;
		spp_mstate_e mstate;
		logic [1:0]  nss_sync;
		logic [1:0]  miso_sync;
		logic [1:0]  done_sync;
		logic        done_seen;
		logic [1:0]  ack_sync;
		logic        tx_req;
		logic [7:0]  rdata;
	} spp_sys_s;

	typedef struct packed {
		logic [1:0] rst_sync;
		logic [1:0] req_sync;
		logic [6:0] rx_sh;
		logic [7:0] rx_byte;
		logic [7:0] tx_sh;
		logic [2:0] cnt;
		logic       done_tgl;
		logic       ack_tgl;
	} spp_link_s;
	spp_sys_s  s_reg;
	spp_sys_s  s_next;
	spp_link_s l_reg;
	spp_link_s l_next;
	logic       port_enable;
	logic       master_enable;
	logic [1:0] slave_select_mode;
	logic       data_wr;
	logic       data_rd;
	logic       ctrl_wr;
	logic       slave_done;
	logic       master_done;
	logic       slave_sel_low;
	assign port_enable       = s_reg.ctrl[SPP_EN_BIT];
	assign master_enable     = s_reg.cfg[SPP_MASTER_ENABLE_BIT];
	assign slave_select_mode = s_reg.ctrl[SPP_MODE_HI:SPP_MODE_LO];
	assign data_wr     = sfr_req.wr && !sfr_req.bit_wr && sfr_req.addr == SPP_DATA_ADDR;
	assign data_rd     = sfr_req.rd && sfr_req.addr == SPP_DATA_ADDR;
	assign ctrl_wr     = sfr_req.wr && sfr_req.addr == SPP_CTRL_ADDR;
	assign slave_done  = s_reg.done_sync[1] != s_reg.done_seen;
	assign master_done = s_reg.mstate == SPP_M_SHIFT && s_reg.div_cnt == 8'h00
		&& s_reg.sck && s_reg.bit_cnt == SPP_BITS_BYTE - 4'h1;
	assign slave_sel_low = slave_select_mode == SPP_MODE_3WIRE || !s_reg.nss_sync[1];
	// ****************************************************************
	// System clock domain
	// ****************************************************************
	always_comb
	begin
		s_next = s_reg;
		s_next.nss_sync  = {s_reg.nss_sync[0], nss_in};
		s_next.miso_sync = {s_reg.miso_sync[0], miso_in};
		s_next.done_sync = {s_reg.done_sync[0], l_reg.done_tgl};
		s_next.done_seen = s_reg.done_sync[1];
		s_next.ack_sync  = {s_reg.ack_sync[0], l_reg.ack_tgl};

		// Software writes first, so hardware events below win over a clear
		if (ctrl_wr && sfr_req.bit_wr)
		begin
			if (sfr_req.bit_idx != 3'(SPP_TXE_BIT))
				s_next.ctrl[sfr_req.bit_idx] = sfr_req.wdata[0];
		end
		else if (ctrl_wr)
		begin
			s_next.ctrl = {sfr_req.wdata[7:2], s_reg.ctrl[SPP_TXE_BIT],
				sfr_req.wdata[0]};
		end
		if (sfr_req.wr && !sfr_req.bit_wr && sfr_req.addr == SPP_CFG_ADDR)
			s_next.cfg = sfr_req.wdata;
		if (sfr_req.wr && !sfr_req.bit_wr && sfr_req.addr == SPP_RATE_ADDR)
			s_next.rate = sfr_req.wdata;

		// Same data path for processor and DMA writes
		if (data_wr)
		begin
			if (!s_reg.ctrl[SPP_TXE_BIT])
				s_next.ctrl[SPP_WRITE_COLLISION_FLAG_BIT] = 1'b1;
			else
			begin
				s_next.tx_buf = sfr_req.wdata;
				s_next.ctrl[SPP_TXE_BIT] = 1'b0;
				if (!master_enable)
					s_next.tx_req = ~s_reg.tx_req;
			end
		end
		if (data_rd)
			s_next.rx_full = 1'b0;
		// Slave hand-off: empty again once the link side loaded the byte
		if (!master_enable && !s_reg.ctrl[SPP_TXE_BIT] && !data_wr
			&& s_reg.ack_sync[1] == s_reg.tx_req)
			s_next.ctrl[SPP_TXE_BIT] = 1'b1;

		if (slave_done && !master_enable && port_enable)
		begin
			s_next.ctrl[SPP_DONE_BIT] = 1'b1;
			if (s_reg.rx_full && !data_rd)
				s_next.ctrl[SPP_OVR_BIT] = 1'b1;
			else
			begin
				s_next.rx_buf  = l_reg.rx_byte;
				s_next.rx_full = 1'b1;
			end
		end

		if (port_enable && master_enable && !s_reg.nss_sync[1]
			&& slave_select_mode == SPP_MODE_4WIRE)
			s_next.ctrl[SPP_MODE_FAULT_FLAG_BIT] = 1'b1;

		// Master shifter, mode with sample on rising clock edge
		unique case (s_reg.mstate)
			SPP_M_IDLE:
			begin
				s_next.sck = 1'b0;
				if (port_enable && master_enable && !s_reg.ctrl[SPP_TXE_BIT])
				begin
					s_next.shift   = s_reg.tx_buf;
					s_next.ctrl[SPP_TXE_BIT] = 1'b1;
					s_next.bit_cnt = 4'h0;
					s_next.div_cnt = s_reg.rate;
					s_next.mstate  = SPP_M_SHIFT;
				end
			end
			SPP_M_SHIFT:
			begin
				if (!port_enable || !master_enable)
				begin
					s_next.mstate = SPP_M_IDLE;
					s_next.sck    = 1'b0;
				end
				else if (s_reg.div_cnt != 8'h00)
					s_next.div_cnt = s_reg.div_cnt - 8'h01;
				else
				begin
					// Each phase lasts rate+1 cycles, never below one
					s_next.div_cnt = s_reg.rate;
					s_next.sck     = ~s_reg.sck;
					if (!s_reg.sck)
						s_next.cap = s_reg.miso_sync[1];
					else
					begin
						s_next.shift   = {s_reg.shift[6:0], s_reg.cap};
						s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
						if (master_done)
						begin
							// One byte in for every byte out
							s_next.rx_buf  = {s_reg.shift[6:0], s_reg.cap};
							s_next.rx_full = 1'b1;
							s_next.ctrl[SPP_DONE_BIT] = 1'b1;
							s_next.mstate  = SPP_M_IDLE;
							// Next byte follows with no gap
							if (!s_reg.ctrl[SPP_TXE_BIT])
							begin
								s_next.shift   = s_reg.tx_buf;
								s_next.ctrl[SPP_TXE_BIT] = 1'b1;
								s_next.bit_cnt = 4'h0;
								s_next.mstate  = SPP_M_SHIFT;
							end
						end
					end
				end
			end
		endcase

		if (sfr_req.rd)
		begin
			unique case (sfr_req.addr)
				SPP_CTRL_ADDR: s_next.rdata = s_reg.ctrl;
				SPP_CFG_ADDR:  s_next.rdata = s_reg.cfg;
				SPP_RATE_ADDR: s_next.rdata = s_reg.rate;
				SPP_DATA_ADDR: s_next.rdata = s_reg.rx_buf;
				default:       s_next.rdata = 8'h00;
			endcase
		end

		if (sys_rst)
		begin
			s_next = '0;
			s_next.ctrl   = SPP_CTRL_RESET;
			s_next.cfg    = SPP_CFG_RESET;
			s_next.rate   = SPP_RATE_RESET;
			s_next.mstate = SPP_M_IDLE;
			s_next.nss_sync = 2'h3;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		s_reg <= s_next;
	end

	// ****************************************************************
	// Link clock domain (slave shifter)
	// ****************************************************************
	// Link clock may stop between frames; everything here advances on edges only
	always_comb
	begin
		l_next = l_reg;
		l_next.rst_sync = {l_reg.rst_sync[0], sys_rst};
		l_next.req_sync = {l_reg.req_sync[0], s_reg.tx_req};
		if (l_reg.rst_sync[1])
		begin
			l_next.rx_sh    = 7'h00;
			l_next.rx_byte  = 8'h00;
			l_next.tx_sh    = SPP_IDLE_BYTE;
			l_next.cnt      = 3'h0;
			l_next.done_tgl = 1'b0;
			l_next.ack_tgl  = 1'b0;
		end
		// Quasi-static mode bits: a stopped link clock cannot synchronise them
		else if (port_enable && !master_enable)
		begin
			// Output moves only after a link edge
			l_next.rx_sh = {l_reg.rx_sh[5:0], mosi_in};
			l_next.tx_sh = {l_reg.tx_sh[6:0], 1'b0};
			l_next.cnt   = l_reg.cnt + 3'h1;
			if (l_reg.cnt == SPP_LAST_BIT)
			begin
				l_next.rx_byte  = {l_reg.rx_sh, mosi_in};
				l_next.done_tgl = ~l_reg.done_tgl;
				// Buffer word is stable while the request is open
				if (l_reg.req_sync[1] != l_reg.ack_tgl)
				begin
					l_next.tx_sh   = s_reg.tx_buf;
					l_next.ack_tgl = ~l_reg.ack_tgl;
				end
				else
					l_next.tx_sh = SPP_IDLE_BYTE;
			end
		end
	end

	always_ff @(posedge link_sck)
	begin
		l_reg <= l_next;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign sfr_rdata   = s_reg.rdata;
	assign dma_tx_req  = port_enable && s_reg.ctrl[SPP_TXE_BIT];
	assign dma_rx_req  = s_reg.rx_full;
	assign sck_pin.o   = s_reg.sck;
	assign sck_pin.oe  = port_enable && master_enable;
	assign mosi_pin.o  = s_reg.shift[7];
	assign mosi_pin.oe = port_enable && master_enable;
	assign miso_pin.o  = l_reg.tx_sh[7];
	assign miso_pin.oe = port_enable && !master_enable && slave_sel_low;
	// Select follows the mode field and the enable bit, never the shifter
	assign nss_pin.o   = slave_select_mode[0];
	assign nss_pin.oe  = port_enable && slave_select_mode[1];

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking spp_cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	write_collision_flag_on_full_a: assert property (data_wr && !s_reg.ctrl[SPP_TXE_BIT]
		|=> s_reg.ctrl[SPP_WRITE_COLLISION_FLAG_BIT] && $stable(s_reg.tx_buf))
		else $error("collision write not flagged or not dropped");
	txe_cleared_a: assert property (data_wr && s_reg.ctrl[SPP_TXE_BIT]
		|=> !s_reg.ctrl[SPP_TXE_BIT] && s_reg.tx_buf == $past(sfr_req.wdata))
		else $error("accepted byte did not clear buffer empty");
	master_autostart_a: assert property (s_reg.mstate == SPP_M_IDLE && port_enable
		&& master_enable && !s_reg.ctrl[SPP_TXE_BIT]
		|=> s_reg.mstate == SPP_M_SHIFT && s_reg.ctrl[SPP_TXE_BIT])
		else $error("master did not start on loaded byte");
	done_sticky_a: assert property (s_reg.ctrl[SPP_DONE_BIT] && !ctrl_wr
		|=> s_reg.ctrl[SPP_DONE_BIT])
		else $error("done flag dropped without a write");
	master_rx_a: assert property (master_done
		|=> s_reg.rx_full && s_reg.ctrl[SPP_DONE_BIT]
		&& s_reg.rx_buf == $past({s_reg.shift[6:0], s_reg.cap}))
		else $error("master byte not captured at end");
	mode_fault_a: assert property (port_enable && master_enable
		&& !s_reg.nss_sync[1] && slave_select_mode == SPP_MODE_4WIRE
		|=> s_reg.ctrl[SPP_MODE_FAULT_FLAG_BIT])
		else $error("mode fault not raised");
	overrun_a: assert property (slave_done && !master_enable && port_enable
		&& s_reg.rx_full && !data_rd
		|=> s_reg.ctrl[SPP_OVR_BIT] && $stable(s_reg.rx_buf))
		else $error("slave overrun not raised");
	select_out_a: assert property (port_enable && slave_select_mode[1]
		|-> nss_pin.oe && nss_pin.o == slave_select_mode[0])
		else $error("select output does not follow mode");
	disable_pins_a: assert property (!port_enable
		|-> !sck_pin.oe && !mosi_pin.oe && !miso_pin.oe)
		else $error("pins driven while port disabled");
	ctrl_reset_a: assert property ($past(sys_rst)
		|-> s_reg.ctrl == SPP_CTRL_RESET)
		else $error("control register reset value wrong");
	sck_phase_a: assert property ($changed(s_reg.sck) && s_reg.mstate == SPP_M_SHIFT
		&& s_reg.rate != 8'h00 && port_enable && master_enable
		|=> $stable(s_reg.sck))
		else $error("master clock phase too short");
	miso_drive_a: assert property ($fell(nss_in) && port_enable
		&& !master_enable && slave_select_mode == SPP_MODE_4WIRE
		##1 (!nss_in && port_enable && !master_enable)[*3]
		|-> miso_pin.oe)
		else $error("slave data out not driven in time");

endmodule

`default_nettype wire

// File: verif/spp_partner.sv
// Partner model: slave for master mode, master for slave mode
`timescale 1ns/1ps
`default_nettype none

module spp_partner
	import spp_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire spp_pin_out_s sck_pin,
	input  wire spp_pin_out_s mosi_pin,
	input  wire spp_pin_out_s miso_pin,
	input  wire logic [7:0]   reply,
	output logic              miso_in,
	output logic              link_sck,
	output logic              mosi_in,
	output logic              nss_drv,
	output logic [7:0]        rx_byte,
	output logic [7:0]        miso_byte,
	output int                frames,
	output logic              oe_seen
);
	logic [7:0] sh;
	logic [2:0] cnt;
	logic       bit_out;

	initial
	begin
		cnt = 3'h0;
		frames = 0;
		link_sck = 1'b0;
		mosi_in = 1'b0;
		nss_drv = 1'b1;
		oe_seen = 1'b0;
	end

	// ********
	// Slave role
	// ********
	// No flow control: every bit taken at the port's own rate
	assign bit_out = reply[3'h7 - cnt];
	// Released line shows the inverse, never a stale copy
	assign miso_in = sck_pin.oe ? bit_out : ~bit_out;

	always @(posedge sck_pin.o)
	begin
		if (sck_pin.oe)
		begin
			sh <= {sh[6:0], mosi_pin.o};
			cnt <= cnt + 3'h1;
			if (cnt == 3'h7)
			begin
				rx_byte <= {sh[6:0], mosi_pin.o};
				frames <= frames + 1;
			end
		end
	end

	// ********
	// Master role
	// ********
	// Link domain reset needs a few edges
	task automatic warm();
		repeat (4)
		begin
			#32 link_sck = 1'b1;
			#32 link_sck = 1'b0;
		end
	endtask

	// Select setup and hold of several cycles, clock only inside frames
	task automatic frame(input logic [7:0] tx);
		nss_drv = 1'b0;
		repeat (4) @(posedge ref_clk);
		#7;
		oe_seen = miso_pin.oe;
		for (int i = 7; i >= 0; i--)
		begin
			// Data moves only in the low phase, held across the sample edge
			mosi_in = tx[i];
			#32 miso_byte = {miso_byte[6:0], miso_pin.o};
			link_sck = 1'b1;
			#32 link_sck = 1'b0;
		end
		mosi_in = ~tx[0];
		repeat (3) @(posedge ref_clk);
		nss_drv <= 1'b1;
	endtask

	// Another master pulls select low for a few cycles
	task automatic pulse_select();
		@(posedge ref_clk);
		nss_drv <= 1'b0;
		repeat (4) @(posedge ref_clk);
		nss_drv <= 1'b1;
	endtask
endmodule

`default_nettype wire

// File: verif/tb.sv
// Testbench: registers, select modes, master and slave transfers of the port
`timescale 1ns/1ps
`default_nettype none

module tb
	import spp_pkg::*;
;
	typedef struct {
		string      nm;
		logic [7:0] exp;
		logic [7:0] msk;
	} spp_note_s;

	logic         ref_clk = 1'b0;
	logic         sys_rst = 1'b1;
	spp_sfr_req_s sfr_req = '0;
	logic [7:0]   sfr_rdata;
	logic         dma_tx_req;
	logic         dma_rx_req;
	logic         link_sck;
	spp_pin_out_s sck_pin;
	spp_pin_out_s mosi_pin;
	spp_pin_out_s miso_pin;
	spp_pin_out_s nss_pin;
	logic         mosi_in;
	logic         miso_in;
	logic         nss_drv;
	wire logic    nss_in;
	logic [7:0]   reply;
	logic [7:0]   rx_byte;
	int           frames;
	logic         oe_seen;
	spp_note_s    notes[$];
	spp_note_s    cur;
	int           err_count = 0;
	int           cmp_count = 0;
	logic [31:0]  lfsr_st = 32'h84F1;
	logic         rd_seen = 1'b0;
	logic [7:0]   a_b;
	logic [7:0]   b_b;
	logic [7:0]   s1;
	logic [7:0]   s2;
	logic [7:0]   miso_byte;

	// Select pin resolved from port drive and partner drive
	assign nss_in = nss_pin.oe ? nss_pin.o : nss_drv;

	initial
	begin
		forever #10 ref_clk = ~ref_clk;
	end

	spp_port uut (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.sfr_req    (sfr_req),
		.sfr_rdata  (sfr_rdata),
		.dma_tx_req (dma_tx_req),
		.dma_rx_req (dma_rx_req),
		.link_sck   (link_sck),
		.sck_pin    (sck_pin),
		.mosi_pin   (mosi_pin),
		.mosi_in    (mosi_in),
		.miso_pin   (miso_pin),
		.miso_in    (miso_in),
		.nss_pin    (nss_pin),
		.nss_in     (nss_in)
	);

	spp_partner far_end (
		.ref_clk  (ref_clk),
		.sck_pin  (sck_pin),
		.mosi_pin (mosi_pin),
		.miso_pin (miso_pin),
		.reply    (reply),
		.miso_in  (miso_in),
		.link_sck (link_sck),
		.mosi_in  (mosi_in),
		.nss_drv  (nss_drv),
		.rx_byte  (rx_byte),
		.miso_byte(miso_byte),
		.frames   (frames),
		.oe_seen  (oe_seen)
	);

	// ********
	// Helpers
	// ********
	function automatic logic [7:0] rnd();
		lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1] ^ lfsr_st[0]};
		return lfsr_st[7:0];
	endfunction

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value %s: expected %h, seen %h", nm, exp, got);
		end
	endtask

	// Ends at a falling edge so pin checks see settled values
	task automatic bus(input logic w, r, b, input logic [2:0] ix, input logic [7:0] ad, dt);
		@(posedge ref_clk);
		sfr_req <= '{wr: w, rd: r, bit_wr: b, bit_idx: ix, addr: ad, wdata: dt};
		@(posedge ref_clk);
		sfr_req <= '0;
		@(negedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] ad, dt);
		bus(1'b1, 1'b0, 1'b0, 3'h0, ad, dt);
	endtask

	task automatic rd(input logic [7:0] ad, msk, exp, input string nm);
		notes.push_back('{nm, exp, msk});
		bus(1'b0, 1'b1, 1'b0, 3'h0, ad, 8'h00);
	endtask

	task automatic wait_frames(input int n);
		for (int k = 0; k < 2000 && frames < n; k++)
			@(posedge ref_clk);
		repeat (20) @(negedge ref_clk);
	endtask

	// Read data lands one cycle after the strobe is taken
	always @(posedge ref_clk)
	begin
		if (rd_seen)
		begin
			cur = notes.pop_front();
			chk(cur.nm, cur.exp & cur.msk, sfr_rdata & cur.msk);
		end
		rd_seen = sfr_req.rd;
	end

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		print_verdict();
	end

	// ********
	// Main sequence
	// ********
	initial
	begin
		reply = rnd();
		fork
			far_end.warm();
		join_none
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(SPP_CTRL_ADDR, 8'hFF, SPP_CTRL_RESET, "ctrl reset");
		rd(SPP_CFG_ADDR, 8'hFF, 8'h00, "cfg reset");
		rd(8'hC0, 8'hFF, 8'h00, "unmapped");
		wr(SPP_CTRL_ADDR, 8'h00);
		rd(SPP_CTRL_ADDR, 8'hFF, 8'h02, "empty bit kept");
		for (int m = 0; m < 4; m++)
		begin
			wr(SPP_CTRL_ADDR, {4'h0, 2'(m), 2'b01});
			chk("select oe", {7'h0, m[1]}, {7'h0, nss_pin.oe});
			if (m > 1)
				chk("select level", {7'h0, m[0]}, {7'h0, nss_pin.o});
		end
		chk("fill request", 8'h01, {7'h0, dma_tx_req});
		wr(SPP_CTRL_ADDR, 8'h0C);
		chk("select oe off", 8'h00, {7'h0, nss_pin.oe});
		wr(SPP_CFG_ADDR, 8'h40);
		wr(SPP_RATE_ADDR, 8'h03);
		wr(SPP_CTRL_ADDR, 8'h09);
		chk("clock oe", 8'h01, {7'h0, sck_pin.oe});
		a_b = rnd();
		b_b = rnd();
		wr(SPP_DATA_ADDR, a_b);
		wr(SPP_DATA_ADDR, b_b);
		rd(SPP_CTRL_ADDR, 8'h02, 8'h00, "buffer full");
		wr(SPP_DATA_ADDR, rnd());
		wait_frames(1);
		chk("first byte out", a_b, rx_byte);
		wait_frames(2);
		chk("second byte out", b_b, rx_byte);
		chk("bytes sent", 8'h02, 8'(frames));
		chk("drain request", 8'h01, {7'h0, dma_rx_req});
		rd(SPP_CTRL_ADDR, 8'hE3, 8'hC3, "master flags");
		rd(SPP_DATA_ADDR, 8'hFF, reply, "master capture");
		for (int b = 7; b > 5; b--)
			bus(1'b1, 1'b0, 1'b1, 3'(b), SPP_CTRL_ADDR, 8'h00);
		rd(SPP_CTRL_ADDR, 8'hE0, 8'h00, "flags cleared");
		wr(SPP_CTRL_ADDR, 8'h0D);
		chk("select released", 8'h01, {7'h0, nss_pin.o});
		wr(SPP_CTRL_ADDR, 8'h05);
		rd(SPP_CTRL_ADDR, 8'h20, 8'h00, "no fault");
		far_end.pulse_select();
		rd(SPP_CTRL_ADDR, 8'h20, 8'h20, "mode fault");
		wr(SPP_CFG_ADDR, 8'h00);
		wr(SPP_CTRL_ADDR, 8'h05);
		s1 = rnd();
		s2 = rnd();
		wr(SPP_DATA_ADDR, s2);
		far_end.frame(s1);
		chk("data out driven", 8'h01, {7'h0, oe_seen});
		chk("slave idle byte", SPP_IDLE_BYTE, miso_byte);
		repeat (4) @(negedge ref_clk);
		chk("data out released", 8'h00, {7'h0, miso_pin.oe});
		far_end.frame(rnd());
		chk("slave byte sent", s2, miso_byte);
		repeat (10) @(negedge ref_clk);
		chk("slave drain", 8'h01, {7'h0, dma_rx_req});
		rd(SPP_CTRL_ADDR, 8'h92, 8'h92, "slave overrun");
		rd(SPP_DATA_ADDR, 8'hFF, s1, "slave byte");
		repeat (4) @(posedge ref_clk);
		print_verdict();
	end
endmodule

`default_nettype wire
